// ==== npc_defines.vh ====
`ifndef NPC_DEFINES_VH
`define NPC_DEFINES_VH
// Command codes
`define NPC_CMD_READ_MODE    8'h00
`define NPC_CMD_PROG_SETUP   8'h80
`define NPC_CMD_RAND_IN      8'h85
`define NPC_CMD_PROG_CONF    8'h10
`define NPC_CMD_CACHE_CONF   8'h15
`define NPC_CMD_READ_CB      8'h35
`define NPC_CMD_ERASE_SETUP  8'h60
`define NPC_CMD_ERASE_CONF   8'hD0
`define NPC_CMD_STATUS       8'h70
`define NPC_CMD_RESET        8'hFF
`define NPC_CMD_READ_CONF    8'h30
// Status bit positions
`define NPC_SR_FAIL          0
`define NPC_SR_PREV_FAIL     1
`define NPC_SR_ARRAY_RDY     5
`define NPC_SR_HOST_RDY      6
`define NPC_SR_NOT_WP        7
// Operation codes on the user port
`define NPC_OP_PROGRAM       3'h0
`define NPC_OP_CACHE_PROG    3'h1
`define NPC_OP_COPYBACK_RD   3'h2
`define NPC_OP_COPYBACK_PROG 3'h3
`define NPC_OP_ERASE         3'h4
`define NPC_OP_STATUS        3'h5
`define NPC_OP_RESET         3'h6
`define NPC_OP_RAND_IN       3'h7
// Timing: strobe half period and wait before sampling ready/busy
`define NPC_T_STROBE_NS      24
`define NPC_STROBE_CYC       ((`NPC_T_STROBE_NS + 7) / 8)
`define NPC_T_WB_NS          100
`define NPC_WB_CYC           ((`NPC_T_WB_NS + 7) / 8)
// Address cycle counts
`define NPC_ADDR_CYC_FULL    5
`define NPC_ADDR_CYC_ROW     3
// Row layout: low bits pick the page inside a block
`define NPC_PAGE_BITS        6
`endif

// ==== npc_dev_model.sv ====
`timescale 1ns/1ns
module npc_dev_model #(
  parameter T_PROG = 40,
  parameter T_ERS  = 60,
  parameter T_RD   = 20
) (
  // Clock
  input  wire       ref_clk,
  // Host pins
  input  wire       cmd_latch, addr_latch, chip_en_n, write_en_n, read_en_n, write_protect_n,
  input  wire [7:0] io_out,
  // Device pins
  output wire [7:0] io_in,
  output wire       ready_busy_n
);
  logic [7:0]  mem [bit [39:0]];
  logic [7:0]  pg [int];
  logic [7:0]  dq = 8'h00;
  logic [15:0] col = 0;
  logic [23:0] row = 0;
  logic        we_q = 1, re_q = 1, st = 0;
  int          hb = 0, ab = 0, na = 0;
  // Released bus shows the inverse of the last byte
  assign io_in = (!chip_en_n && !read_en_n) ? dq : ~dq;
  assign ready_busy_n = hb == 0;
  always @(posedge ref_clk) begin
    we_q <= write_en_n;
    re_q <= read_en_n;
    if (hb > 0) hb <= hb - 1;
    if (ab > 0) ab <= ab - 1;
    if (!chip_en_n && write_en_n && !we_q) begin
      if (cmd_latch) begin
        st <= io_out == 8'h70;
        na <= io_out == 8'h60 ? 2 : 0;
        case (io_out)
          8'h80: pg.delete();
          8'h10, 8'h15: if (write_protect_n) begin
            foreach (pg[i]) mem[{row, i[15:0]}] = pg[i];
            ab <= ab + T_PROG;
            hb <= io_out == 8'h15 ? 4 : ab + T_PROG;
          end
          8'hD0: if (write_protect_n) begin
            foreach (mem[k]) if (k[39:22] == row[23:6]) mem[k] = 8'hFF;
            hb <= T_ERS;
          end
          8'h30, 8'h35: begin
            for (int i = 0; i < 4352; i++) pg[i] = mem.exists({row, i[15:0]}) ? mem[{row, i[15:0]}] : 8'hFF;
            hb <= T_RD;
          end
          8'hFF: begin
            hb <= 5;
            ab <= 0;
          end
          default: ; // Random input keeps the page
        endcase
      end else if (addr_latch) begin
        if (na < 2) col[8*na +: 8] <= io_out;
        else row[8*(na-2) +: 8] <= io_out;
        na <= na + 1;
      end else begin
        pg[col] = io_out;
        col <= col + 1;
      end
    end
    if (!chip_en_n && !read_en_n && re_q) begin
      dq <= st ? {write_protect_n, hb == 0, ab == 0, 5'h00} : pg[col];
      if (!st) col <= col + 1;
    end
  end
endmodule

// ==== npc_host.v ====
`timescale 1ns/1ns
`include "npc_defines.vh"
module npc_host #(
  parameter AW = 13
) (
  // Clock and reset
  input  wire          ref_clk,
  input  wire          rst,
  // User command port
  input  wire          op_valid,
  input  wire [2:0]    op_code,
  input  wire [15:0]   op_column,
  input  wire [23:0]   op_row,
  input  wire [AW-1:0] op_len,
  input  wire          wp_allow,
  output reg           op_ready,
  output reg           op_done,
  output reg  [7:0]    op_status,
  output reg           op_fail,
  // User page buffer load and flash read data out
  input  wire          buf_wr_en,
  input  wire [AW-1:0] buf_wr_addr,
  input  wire [7:0]    buf_wr_data,
  output reg           rd_valid,
  output reg  [7:0]    rd_data,
  // Flash pins
  output reg           cmd_latch,
  output reg           addr_latch,
  output reg           chip_en_n,
  output reg           write_en_n,
  output reg           read_en_n,
  output reg           write_protect_n,
  output reg  [7:0]    io_out,
  output reg           io_oe,
  input  wire [7:0]    io_in,
  input  wire          ready_busy_n
);
  localparam S_IDLE = 4'd0, S_CMD1 = 4'd1, S_ADDR = 4'd2, S_DATA = 4'd3, S_CMD2 = 4'd4;
  localparam S_WB = 4'd5, S_BUSY = 4'd6, S_SCMD = 4'd7, S_SRD = 4'd8, S_DONE = 4'd9;
  localparam S_RDOUT = 4'd10, S_RMODE = 4'd11;
  localparam integer STROBE_I = `NPC_STROBE_CYC;
  localparam integer WB_I     = `NPC_WB_CYC;
  localparam integer NROW_I   = `NPC_ADDR_CYC_ROW;
  localparam integer NFULL_I  = `NPC_ADDR_CYC_FULL;
  localparam [7:0]   STROBE   = STROBE_I[7:0];
  localparam [7:0]   WB       = WB_I[7:0];

  reg [3:0]    st_q;
  reg [7:0]    tmr_q;
  reg          ph_q;
  reg [2:0]    op_q;
  reg [15:0]   col_q;
  reg [23:0]   row_q;
  reg [AW-1:0] len_q;
  reg [AW-1:0] idx_q;
  reg [2:0]    acnt_q;
  reg          boot_q;
  reg [23:0]   last_row_q;
  reg          trk_q;
  reg          cache_open_q;
  reg [AW-1:0] mem_ra;
  wire [7:0]   mem_rd;

  npc_page_mem #(.DW(8), .AW(AW)) u_mem (
    .ref_clk (ref_clk),
    .wr_en   (buf_wr_en),
    .wr_addr (buf_wr_addr),
    .wr_data (buf_wr_data),
    .rd_addr (mem_ra),
    .rd_data (mem_rd)
  );

  // Address byte for cycle n
  function [7:0] addr_byte;
    input [2:0]  n;
    input [15:0] c;
    input [23:0] r;
    input        row_only;
    begin
      if (row_only) begin
        addr_byte = r[8*n +: 8];
      end else if (n < 3'd2) begin
        addr_byte = c[8*n +: 8];
      end else begin
        addr_byte = r[8*(n-3'd2) +: 8];
      end
    end
  endfunction

  // Opening command for each operation
  function [7:0] first_cmd;
    input [2:0] op;
    begin
      case (op)
        `NPC_OP_COPYBACK_RD:   first_cmd = `NPC_CMD_READ_MODE;
        `NPC_OP_COPYBACK_PROG: first_cmd = `NPC_CMD_RAND_IN;
        `NPC_OP_ERASE:         first_cmd = `NPC_CMD_ERASE_SETUP;
        `NPC_OP_STATUS:        first_cmd = `NPC_CMD_STATUS;
        `NPC_OP_RESET:         first_cmd = `NPC_CMD_RESET;
        `NPC_OP_RAND_IN:       first_cmd = `NPC_CMD_RAND_IN;
        default:               first_cmd = `NPC_CMD_PROG_SETUP;
      endcase
    end
  endfunction

  wire is_prog = (op_q == `NPC_OP_PROGRAM) || (op_q == `NPC_OP_CACHE_PROG) || (op_q == `NPC_OP_COPYBACK_PROG);
  wire has_data = (op_q == `NPC_OP_PROGRAM) || (op_q == `NPC_OP_CACHE_PROG) || (op_q == `NPC_OP_RAND_IN);
  wire tick = (tmr_q == 8'h00);
  // Two rows fall in one erase block
  function same_blk;
    input [23:0] a;
    input [23:0] b;
    begin
      same_blk = (a >> `NPC_PAGE_BITS) == (b >> `NPC_PAGE_BITS);
    end
  endfunction

  wire [2:0] n_addr = (op_q == `NPC_OP_ERASE) ? NROW_I[2:0] :
                      (op_q == `NPC_OP_RAND_IN) ? 3'h2 : NFULL_I[2:0];
  wire new_prog = (op_code == `NPC_OP_PROGRAM) || (op_code == `NPC_OP_CACHE_PROG) ||
                  (op_code == `NPC_OP_COPYBACK_PROG);
  // Same page again, or an earlier one, since the last erase
  wire out_of_order = trk_q && same_blk(op_row, last_row_q) &&
                      (op_row[`NPC_PAGE_BITS-1:0] <= last_row_q[`NPC_PAGE_BITS-1:0]);
  wire cross_blk = cache_open_q && !same_blk(op_row, last_row_q);
  wire refuse = new_prog && (out_of_order || cross_blk);

  always @* begin
    mem_ra = idx_q;
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      st_q <= S_IDLE; tmr_q <= 8'h00; ph_q <= 1'b0; op_q <= 3'h0;
      col_q <= 16'h0000; row_q <= 24'h000000; len_q <= {AW{1'b0}}; idx_q <= {AW{1'b0}};
      acnt_q <= 3'h0; boot_q <= 1'b1;
      last_row_q <= 24'h000000; trk_q <= 1'b0; cache_open_q <= 1'b0;
      op_ready <= 1'b0; op_done <= 1'b0; op_status <= 8'h00; op_fail <= 1'b0;
      rd_valid <= 1'b0; rd_data <= 8'h00;
      cmd_latch <= 1'b0; addr_latch <= 1'b0; chip_en_n <= 1'b1; write_en_n <= 1'b1;
      read_en_n <= 1'b1; write_protect_n <= 1'b0; io_out <= 8'h00; io_oe <= 1'b0;
    end else begin
      op_done <= 1'b0;
      rd_valid <= 1'b0;
      if (!tick) tmr_q <= tmr_q - 8'h01;
      case (st_q)
        S_IDLE: begin
          cmd_latch <= 1'b0; addr_latch <= 1'b0; io_oe <= 1'b0;
          // Protect level is frozen from the take until the op is done
          write_protect_n <= wp_allow;
          if (boot_q) begin
            op_ready <= 1'b0;
            if (ready_busy_n) boot_q <= 1'b0;
          end else begin
            op_ready <= 1'b1;
            if (op_valid) begin
              op_ready <= 1'b0; op_q <= op_code; col_q <= op_column; row_q <= op_row;
              len_q <= op_len; idx_q <= {AW{1'b0}}; acnt_q <= 3'h0; ph_q <= 1'b0;
              chip_en_n <= 1'b0; tmr_q <= STROBE; st_q <= S_CMD1;
              if (refuse) begin
                // Refused without touching the pins
                chip_en_n <= 1'b1;
                op_fail <= 1'b1;
                st_q <= S_DONE;
              end else if (new_prog) begin
                trk_q <= 1'b1;
                last_row_q <= op_row;
                cache_open_q <= (op_code == `NPC_OP_CACHE_PROG);
              end else if (op_code == `NPC_OP_ERASE && same_blk(op_row, last_row_q)) begin
                trk_q <= 1'b0;
                cache_open_q <= 1'b0;
              end
            end
          end
        end
        S_CMD1, S_CMD2, S_SCMD, S_RMODE, S_ADDR, S_DATA: if (tick) begin
          ph_q <= ~ph_q; tmr_q <= STROBE;
          if (!ph_q) begin
            write_en_n <= 1'b0; io_oe <= 1'b1;
            cmd_latch <= (st_q != S_ADDR) && (st_q != S_DATA);
            addr_latch <= (st_q == S_ADDR);
            case (st_q)
              S_CMD1:  io_out <= first_cmd(op_q);
              S_SCMD:  io_out <= `NPC_CMD_STATUS;
              S_RMODE: io_out <= `NPC_CMD_READ_MODE;
              S_ADDR:  io_out <= addr_byte(acnt_q, col_q, row_q, op_q == `NPC_OP_ERASE);
              S_DATA:  io_out <= mem_rd;
              default: io_out <= (op_q == `NPC_OP_ERASE) ? `NPC_CMD_ERASE_CONF :
                                 (op_q == `NPC_OP_CACHE_PROG) ? `NPC_CMD_CACHE_CONF :
                                 (op_q == `NPC_OP_COPYBACK_RD) ? `NPC_CMD_READ_CB : `NPC_CMD_PROG_CONF;
            endcase
          end else begin
            write_en_n <= 1'b1;
            case (st_q)
              S_CMD1: begin
                if (op_q == `NPC_OP_STATUS) st_q <= S_SRD;
                else if (op_q == `NPC_OP_RESET) begin tmr_q <= WB; st_q <= S_WB; end
                else st_q <= S_ADDR;
              end
              S_ADDR: begin
                acnt_q <= acnt_q + 3'h1;
                if (acnt_q == n_addr - 3'h1) begin
                  idx_q <= col_q[AW-1:0];
                  st_q <= (has_data && len_q != {AW{1'b0}}) ? S_DATA :
                          (op_q == `NPC_OP_RAND_IN) ? S_DONE : S_CMD2;
                end
              end
              S_DATA: begin
                idx_q <= idx_q + {{(AW-1){1'b0}}, 1'b1};
                if (idx_q - col_q[AW-1:0] == len_q - {{(AW-1){1'b0}}, 1'b1})
                  st_q <= (op_q == `NPC_OP_RAND_IN) ? S_DONE : S_CMD2;
              end
              S_CMD2: begin tmr_q <= WB; st_q <= S_WB; end
              S_SCMD: st_q <= S_SRD;
              default: begin idx_q <= {AW{1'b0}}; st_q <= S_RDOUT; end
            endcase
          end
        end
        S_WB: begin
          cmd_latch <= 1'b0; io_oe <= 1'b0;
          if (tick) st_q <= S_BUSY;
        end
        S_BUSY: if (ready_busy_n) begin
          st_q <= (op_q == `NPC_OP_RESET) ? S_DONE : S_SCMD;
          tmr_q <= STROBE;
        end
        S_SRD: if (tick) begin
          ph_q <= ~ph_q; tmr_q <= STROBE; io_oe <= 1'b0; cmd_latch <= 1'b0;
          if (!ph_q) begin
            read_en_n <= 1'b0;
          end else begin
            read_en_n <= 1'b1;
            op_status <= io_in;
            // Cache: bit0 valid with bit5, bit1 with bit6; others bit0 with bit6
            if (op_q == `NPC_OP_CACHE_PROG)
              op_fail <= (io_in[`NPC_SR_ARRAY_RDY] & io_in[`NPC_SR_FAIL]) |
                         (io_in[`NPC_SR_HOST_RDY] & io_in[`NPC_SR_PREV_FAIL]);
            else
              op_fail <= io_in[`NPC_SR_HOST_RDY] & io_in[`NPC_SR_FAIL] |
                         (is_prog | (op_q == `NPC_OP_ERASE)) & ~io_in[`NPC_SR_NOT_WP];
            st_q <= (op_q == `NPC_OP_COPYBACK_RD) ? S_RMODE : S_DONE;
          end
        end
        S_RDOUT: if (tick) begin
          ph_q <= ~ph_q; tmr_q <= STROBE;
          if (!ph_q) begin
            read_en_n <= 1'b0;
          end else begin
            read_en_n <= 1'b1; rd_valid <= 1'b1; rd_data <= io_in;
            idx_q <= idx_q + {{(AW-1){1'b0}}, 1'b1};
            if (idx_q == len_q - {{(AW-1){1'b0}}, 1'b1} || len_q == {AW{1'b0}}) st_q <= S_DONE;
          end
        end
        S_DONE: begin
          chip_en_n <= 1'b1; io_oe <= 1'b0; op_done <= 1'b1;
          write_protect_n <= wp_allow; st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== npc_host_chk.sv ====
`timescale 1ns/1ns
module npc_host_chk (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Watched ports
  input wire op_valid, op_ready, op_done, cmd_latch, addr_latch, io_oe,
  input wire chip_en_n, write_en_n, read_en_n, write_protect_n, ready_busy_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  rst_idle_a: assert property (disable iff (1'b0) rst |=> !op_ready && chip_en_n && !io_oe && !write_protect_n)
    else $error("pins not idle in reset");
  wp_hold_a: assert property ($fell(write_protect_n) |-> $past(ready_busy_n))
    else $error("protect lowered while busy");
  we_pulse_a: assert property ($fell(write_en_n) |-> !write_en_n [*4] ##1 write_en_n)
    else $error("write strobe width");
  wp_steady_a: assert property (!ready_busy_n |-> $stable(write_protect_n))
    else $error("protect changed while busy");
  latch_excl_a: assert property (!(cmd_latch && addr_latch))
    else $error("both latches high");
  sel_strobe_a: assert property (!write_en_n || !read_en_n |-> !chip_en_n)
    else $error("strobe without select");
  strobe_excl_a: assert property (!(!write_en_n && !read_en_n))
    else $error("both strobes low");
  take_busy_a: assert property (op_valid && op_ready |=> !op_ready)
    else $error("ready after take");
  done_ready_a: assert property (op_done |-> !op_ready ##[1:2] op_ready)
    else $error("ready not back after done");
endmodule
bind npc_host npc_host_chk u_chk (.ref_clk, .rst, .op_valid, .op_ready, .op_done, .cmd_latch, .addr_latch, .io_oe,
  .chip_en_n, .write_en_n, .read_en_n, .write_protect_n, .ready_busy_n);

// ==== npc_host_tb.sv ====
`timescale 1ns/1ns
module npc_host_tb;
  logic        ref_clk = 0, rst = 1, op_valid = 0, wp_allow = 1, buf_wr_en = 0;
  logic [2:0]  op_code = 0;
  logic [15:0] op_column = 0;
  logic [23:0] op_row = 0;
  logic [12:0] op_len = 0, buf_wr_addr = 0;
  logic [7:0]  buf_wr_data = 0;
  wire         op_ready, op_done, op_fail, rd_valid, cmd_latch, addr_latch, chip_en_n;
  wire         write_en_n, read_en_n, write_protect_n, io_oe, ready_busy_n;
  wire  [7:0]  op_status, rd_data, io_out, io_in;
  int          err_count = 0, n_compared = 0, cyc = 0, seed = 32'h8D54;
  logic [7:0]  ref_mem [bit [39:0]];
  logic [7:0]  got [$];
  always #4 ref_clk = ~ref_clk;
  npc_host u_dut (.ref_clk, .rst, .op_valid, .op_code, .op_column, .op_row, .op_len, .wp_allow, .op_ready,
    .op_done, .op_status, .op_fail, .buf_wr_en, .buf_wr_addr, .buf_wr_data, .rd_valid, .rd_data, .cmd_latch,
    .addr_latch, .chip_en_n, .write_en_n, .read_en_n, .write_protect_n, .io_out, .io_oe, .io_in, .ready_busy_n);
  npc_dev_model u_dev (.ref_clk, .cmd_latch, .addr_latch, .chip_en_n, .write_en_n, .read_en_n,
    .write_protect_n, .io_out, .io_in, .ready_busy_n);
  function logic [7:0] ex(logic [23:0] r, int i);
    return ref_mem.exists({r, i[15:0]}) ? ref_mem[{r, i[15:0]}] : 8'hFF;
  endfunction
  task close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task load(logic [23:0] r, int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      d = $random(seed);
      buf_wr_en <= 1;
      buf_wr_addr <= i[12:0];
      buf_wr_data <= d;
      ref_mem[{r, i[15:0]}] = d;
    end
    @(posedge ref_clk);
    buf_wr_en <= 0;
  endtask
  task run(logic [2:0] c, logic [23:0] r, logic [12:0] n);
    int t;
    got = {};
    @(posedge ref_clk);
    op_valid <= 1;
    op_code <= c;
    op_row <= r;
    op_len <= n;
    do @(posedge ref_clk); while (op_ready !== 1'b1);
    op_valid <= 0;
    for (t = 0; t < 4000 && op_done !== 1'b1; t++) begin
      @(posedge ref_clk);
      if (rd_valid === 1'b1) got.push_back(rd_data);
    end
    chk("done", 1, {7'h00, op_done});
  endtask
  task rdback(logic [23:0] r);
    run(2, r, 8);
    chk("count", 8, 8'(got.size()));
    foreach (got[i]) chk("data", ex(r, i), got[i]);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    load(24'h41, 8);
    run(0, 24'h41, 8);
    chk("status", 8'hE0, op_status);
    chk("fail", 0, {7'h00, op_fail});
    rdback(24'h41);
    $display("test program done");
    for (int i = 4; i < 8; i++) ref_mem[{24'h42, i[15:0]}] = ex(24'h41, i);
    load(24'h42, 4);
    run(7, 24'h42, 4);
    run(3, 24'h42, 0);
    chk("status", 8'hE0, op_status);
    rdback(24'h42);
    $display("test copy-back done");
    load(24'h43, 8);
    run(1, 24'h43, 8);
    load(24'h44, 8);
    run(0, 24'h44, 8);
    chk("status", 8'hE0, op_status);
    rdback(24'h43);
    rdback(24'h44);
    $display("test cache done");
    run(4, 24'h7F, 0);
    ref_mem.delete();
    chk("status", 8'hE0, op_status);
    rdback(24'h44);
    $display("test erase done");
    wp_allow <= 0;
    load(24'h80, 8);
    ref_mem.delete();
    run(0, 24'h80, 8);
    chk("status", 8'h60, op_status);
    chk("fail", 1, {7'h00, op_fail});
    wp_allow <= 1;
    rdback(24'h80);
    $display("test protect done");
    run(5, 0, 0);
    chk("status", 8'hE0, op_status);
    run(6, 0, 0);
    run(5, 0, 0);
    chk("status", 8'hE0, op_status);
    $display("test reset done");
    run(0, 24'h80, 0);
    chk("fail", 1, {7'h00, op_fail});
    run(1, 24'hC1, 0);
    chk("fail", 0, {7'h00, op_fail});
    run(0, 24'h101, 0);
    chk("fail", 1, {7'h00, op_fail});
    $display("test order done");
    close_out();
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end
endmodule

// ==== npc_page_mem.v ====
`timescale 1ns/1ns
module npc_page_mem #(
  parameter DW = 8,
  parameter AW = 13
) (
  // Clock
  input  wire          ref_clk,
  // Write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  // Read port
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
